// ===== pdr_pin_direction.v
// Purpose: Per-group pin direction registers behind an AHB-Lite slave
// Assumes: Single clock, synchronous active-high reset, word accesses
// Notes: Mask registers read back the shared direction state
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_consts.vh"
module pdr_pin_direction #(
	parameter GROUPS = 2,
	parameter PINS = 32
)
(
	input wire clk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire peripheral_access_guard,
	output wire [GROUPS*32-1:0] pin_direction
);
	// ****************************************
	// Address phase capture
	// ****************************************
	reg wr_pend_reg;
	reg [31:0] wr_addr_reg;
	reg guard_meta_reg;
	reg guard_sync_reg;
	reg [31:0] dir_reg [0:GROUPS-1];
	reg [31:0] dir_next [0:GROUPS-1];
	wire take;
	integer g;

	function [31:0] group_of;
		input [31:0] addr;
		begin
			group_of = addr >> `PDR_GROUP_SHIFT;
		end
	endfunction

	function [31:0] pin_mask;
		input dummy;
		integer i;
		begin
			pin_mask = 32'h00000000;
			for (i = 0; i < 32; i = i + 1)
				if (i < PINS)
					pin_mask[i] = 1'b1;
			pin_mask = pin_mask & {31'h00000000, 1'b1 | dummy} | pin_mask;
		end
	endfunction

	assign take = hsel && hready && (htrans == `PDR_HTRANS_NONSEQ || htrans == `PDR_HTRANS_SEQ);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Guard comes from another block's pin; synchronise it
	always @(posedge clk)
	begin
		if (reset)
		begin
			guard_meta_reg <= 1'b0;
			guard_sync_reg <= 1'b0;
		end
		else
		begin
			guard_meta_reg <= peripheral_access_guard;
			guard_sync_reg <= guard_meta_reg;
		end
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h00000000;
			hrdata <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= take && hwrite;
			if (take)
				wr_addr_reg <= haddr;
			if (take && !hwrite && group_of(haddr) < GROUPS && haddr[6:4] == 3'h0 && haddr[1:0] == 2'h0)
				hrdata <= dir_reg[group_of(haddr)];
			else
				hrdata <= 32'h00000000;
		end
	end

	// ****************************************
	// Direction state update
	// ****************************************
	always @*
	begin
		for (g = 0; g < GROUPS; g = g + 1)
		begin
			dir_next[g] = dir_reg[g];
			if (wr_pend_reg && !guard_sync_reg && group_of(wr_addr_reg) == g)
			begin
				case (wr_addr_reg[6:0])
					`PDR_OFS_DIR: dir_next[g] = hwdata & pin_mask(1'b0);
					`PDR_OFS_CLR: dir_next[g] = dir_reg[g] & ~hwdata;
					`PDR_OFS_SET: dir_next[g] = (dir_reg[g] | hwdata) & pin_mask(1'b0);
					`PDR_OFS_TGL: dir_next[g] = (dir_reg[g] ^ hwdata) & pin_mask(1'b0);
					default: dir_next[g] = dir_reg[g];
				endcase
			end
		end
	end

	always @(posedge clk)
	begin
		for (g = 0; g < GROUPS; g = g + 1)
			if (reset)
				dir_reg[g] <= `PDR_DIR_RESET;
			else
				dir_reg[g] <= dir_next[g];
	end

	genvar k;
	generate
		for (k = 0; k < GROUPS; k = k + 1)
		begin : out_g
			assign pin_direction[k*32 +: 32] = dir_reg[k];
		end
	endgenerate
endmodule
`default_nettype wire

// ===== pdr_consts.vh
// Purpose: Constants for the pin direction register block
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes: Group copies repeat every GROUP_STRIDE bytes
`ifndef PDR_CONSTS_VH
`define PDR_CONSTS_VH
`define PDR_OFS_DIR 7'h00
`define PDR_OFS_CLR 7'h04
`define PDR_OFS_SET 7'h08
`define PDR_OFS_TGL 7'h0C
`define PDR_GROUP_STRIDE 32'h00000080
`define PDR_GROUP_SHIFT 7
`define PDR_DIR_RESET 32'h00000000
`define PDR_HTRANS_NONSEQ 2'h2
`define PDR_HTRANS_SEQ 2'h3
`define PDR_HSIZE_WORD 3'h2
`endif

// ===== pdr_chk_assertions.sv
// Purpose: checker. Assumes: hsel high. Notes: -
`timescale 1ns/1ps
`default_nettype none
module pdr_chk(input wire logic clk,reset,hsel,hready,hwrite,peripheral_access_guard,input wire logic [1:0] htrans,
input wire logic [31:0] haddr,hwdata,input wire logic [63:0] pin_direction);
logic wv,gm,gs;
logic [8:0] wa;
always_ff @(posedge clk) begin
wv<=!reset&&hsel&&hready&&htrans[1]&&hwrite;
wa<=haddr[8:0];
gm<=!reset&&peripheral_access_guard;
gs<=!reset&&gm;
end
default clocking @(posedge clk); endclocking
default disable iff (reset);
clr_bits_a: assert property(wv&&!gs&&wa==9'h004|=>(pin_direction[31:0]&$past(hwdata))==0) else $error("clr");
clr_keep_a: assert property(wv&&!gs&&wa==9'h004|=>(pin_direction[31:0]|$past(hwdata))==($past(pin_direction[31:0])|$past(hwdata))) else $error("clr keep");
set_bits_a: assert property(wv&&!gs&&wa==9'h088|=>(pin_direction[63:32]&$past(hwdata))==$past(hwdata)) else $error("set");
set_keep_a: assert property(wv&&!gs&&wa==9'h088|=>(pin_direction[63:32]&~$past(hwdata))==($past(pin_direction[63:32])&~$past(hwdata))) else $error("set keep");
group_apart_a: assert property(wv&&!gs&&wa[8:7]==2'h1|=>pin_direction[31:0]==$past(pin_direction[31:0])) else $error("group");
guard_sync_a: assert property(gs|=>$stable(pin_direction)) else $error("guard sync");
guard_hold_a: assert property(peripheral_access_guard[*4]|=>$stable(pin_direction)) else $error("guard");
endmodule
bind pdr_pin_direction pdr_chk chk(.*);
`default_nettype wire

// ===== pdr_pins.sv
// Purpose: pins. Assumes: -. Notes: -
`timescale 1ns/1ps
`default_nettype none
module pdr_pins(input wire logic [63:0] pin_direction,output logic [63:0] seen);
assign seen=pin_direction;
endmodule
`default_nettype wire

// ===== pdr_pin_direction_bench.sv
// Purpose: bench. Assumes: -. Notes: -
`timescale 1ns/1ps
`default_nettype none
module pdr_pin_direction_bench;
logic clk=0,reset=1,hsel=1,hwrite=0,peripheral_access_guard=0;
logic [1:0] htrans=0;
logic [31:0] haddr=0,hwdata=0,d=19,a,c,m[4]='{0,0,0,0};
wire hready,hresp;
wire [31:0] hrdata;
wire [63:0] pin_direction,seen;
int failures=0,checked=0,i;
always #4 clk=~clk;
pdr_pin_direction dut(.*,.hsize(3'h2),.hreadyout(hready));
pdr_pins far(.*);
function logic [31:0] lf(logic [31:0] x);
	return {x[30:0],x[31]^x[21]^x[1]^x[0]};
endfunction
task automatic chk(input logic [31:0] e,g);
	checked++;
	failures+=g!==e;
	if(g!==e) $display("Error data exp %h got %h",e,g);
endtask
task automatic bus(input logic [31:0] ad,dt,input logic w);
	htrans<=2'h2; hwrite<=w; haddr<=ad;
	do @(posedge clk); while(hready!==1);
	htrans<=0; hwdata<=dt;
	do @(posedge clk); while(hready!==1);
endtask
task summarize;
	$display("checked %0d failures %0d",checked,failures);
	if(failures==0&&checked>0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
initial #20000 begin failures++; summarize; end
initial
begin
	repeat(6) @(posedge clk);
	reset<=0;
	for(i=0;i<60;i++)
	begin
		peripheral_access_guard<=i>49;
		d=lf(d);
		a={23'h0,d[20:19],3'h0,d[3:2],2'h0};
		bus(a,d,1);
		c=m[a[7]];
		if(!a[8]&&i<51) m[a[7]]=a[3:2]==0?d:a[3:2]==1?c&~d:a[3:2]==2?c|d:c^d;
		bus(a,0,0);
		chk(m[a[8:7]],hrdata);
	end
	chk(m[0],seen[31:0]);
	chk(m[1],seen[63:32]);
	summarize;
end
endmodule
`default_nettype wire
